// >>> core/rtcs_special_regs.sv
/*
  Control, charge-select and halt-flag registers of a serial real-time
  clock, the oscillator divider chain with digital calibration, the
  test/level pin, the charger switch decode and oscillator stop sensing.
  Assumes a serial-bus slave outside that loads the pointer and issues
  one write or read strobe per data byte, and timekeeping outside that
  owns pointers 00h to 06h and consumes the one-second tick.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcs_special_regs (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Oscillator pin and its disable bit from register 0
  input  wire logic       osc_clk,
  input  wire logic       osc_disable_n,
  output logic            osc_enable,
  // Byte access from the serial slave
  input  wire logic       ptr_load,
  input  wire logic [7:0] ptr_value,
  input  wire logic       wr_stb,
  input  wire logic [7:0] wr_data,
  input  wire logic       rd_stb,
  output logic      [7:0] reg_ptr,
  output logic      [7:0] rd_data,
  // Test/level pin and timekeeping tick
  output logic            test_level_pin,
  output logic            sec_tick,
  // Charger switches
  output logic            chg_enable,
  output logic            chg_diode,
  output logic            chg_res_250,
  output logic            chg_res_2k,
  output logic            chg_res_4k,
  // Status
  output logic            halt_flag
);

  logic                             osc_rise;
  logic                             osc_edge;
  logic                             ctrl_wr;
  logic                             flag_clr;
  logic                             halt_evt;
  logic                             adj_now;
  logic [7:0]                       ptr_q,   ptr_d;
  logic [7:0]                       ctrl_q,  ctrl_d;
  logic [7:0]                       chg_q,   chg_d;
  logic                             flag_q,  flag_d;
  logic [7:0]                       rdat_q,  rdat_d;
  logic                             run_q,   run_d;
  logic [rtcs_pkg::STOP_W-1:0]      idle_q,  idle_d;
  logic [rtcs_pkg::TONE_W-1:0]      tone_q,  tone_d;
  logic [rtcs_pkg::PRE_W-1:0]       pre_q,   pre_d;
  logic [rtcs_pkg::STAGE_W-1:0]     stage_q, stage_d;
  logic [7:0]                       blank_q, blank_d;
  logic [5:0]                       sec_q,   sec_d;
  logic [5:0]                       min_q,   min_d;
  logic                             tick_q,  tick_d;
  rtcs_pkg::rtcs_cal_t              cal_q,   cal_d;
  logic                             pin_q,   pin_d;
  logic [4:0]                       sw_q,    sw_d;

  // Oscillator arrives from a pin, so it crosses two flops first
  rtcs_edge_sync u_osc_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in (osc_clk),
    .level    (),
    .rise     (osc_rise)
  );

  // Edges are ignored while software holds the oscillator off
  assign osc_enable = ~osc_disable_n;
  assign osc_edge   = osc_rise & ~osc_disable_n;
  assign ctrl_wr    = wr_stb && (ptr_q == rtcs_pkg::PTR_CTRL);
  assign flag_clr   = wr_stb && (ptr_q == rtcs_pkg::PTR_FLAG) && !wr_data[rtcs_pkg::FLAG_BIT];

  // Stop sensing: no edge within the timeout, or disabled, means stopped
  always_comb begin
    run_d  = run_q;
    idle_d = idle_q;
    if (osc_disable_n) begin
      run_d  = 1'b0;
      idle_d = '0;
    end else if (osc_edge) begin
      run_d  = 1'b1;
      idle_d = '0;
    end else if (idle_q == rtcs_pkg::STOP_W'(rtcs_pkg::OSC_STOP_CYCLES - 1)) begin
      run_d  = 1'b0;
    end else begin
      idle_d = idle_q + 1'b1;
    end
  end

  // Only the falling edge of the run state counts, never the level
  assign halt_evt = run_q && !run_d;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      run_q  <= 1'b0;
      idle_q <= '0;
    end else begin
      run_q  <= run_d;
      idle_q <= idle_d;
    end
  end

  // Register file, pointer and read data
  always_comb begin
    ptr_d  = ptr_q;
    ctrl_d = ctrl_q;
    chg_d  = chg_q;
    flag_d = flag_q;
    if (ptr_load) begin
      ptr_d = ptr_value;
    end else if (wr_stb || rd_stb) begin
      if (ptr_q == rtcs_pkg::PTR_CTRL || ptr_q == rtcs_pkg::PTR_FLAG) begin
        ptr_d = rtcs_pkg::PTR_ZERO;
      end else begin
        ptr_d = ptr_q + 8'h01;
      end
    end
    if (ctrl_wr) begin
      ctrl_d = wr_data;
    end
    if (wr_stb && ptr_q == rtcs_pkg::PTR_CHG) begin
      chg_d = wr_data;
    end
    // Writing 1 is a no-op; a stop event in the clear cycle still wins
    if (flag_clr) begin
      flag_d = 1'b0;
    end
    if (halt_evt) begin
      flag_d = 1'b1;
    end
    case (ptr_q)
      rtcs_pkg::PTR_CTRL: rdat_d = ctrl_q;
      rtcs_pkg::PTR_CHG:  rdat_d = chg_q;
      rtcs_pkg::PTR_FLAG: rdat_d = {flag_q, 7'h00};
      default:            rdat_d = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q  <= rtcs_pkg::PTR_ZERO;
      ctrl_q <= rtcs_pkg::CTRL_RESET;
      chg_q  <= rtcs_pkg::CHG_RESET;
      flag_q <= rtcs_pkg::FLAG_RESET;
      rdat_q <= 8'h00;
    end else begin
      ptr_q  <= ptr_d;
      ctrl_q <= ctrl_d;
      chg_q  <= chg_d;
      flag_q <= flag_d;
      rdat_q <= rdat_d;
    end
  end

  // Second counts inside the minute and minute inside the 64-minute cycle
  assign adj_now = (sec_q == rtcs_pkg::ADJ_SECOND)
                   && (min_q < {ctrl_q[rtcs_pkg::TRIM_W-1:0], 1'b0})
                   && (min_q < rtcs_pkg::CAL_MIN_LIM);

  // Divider chain with calibration at the /256 prescaler
  always_comb begin
    logic [rtcs_pkg::STAGE_W:0] sum;
    logic                       pos;
    sum     = '0;
    pos     = ctrl_q[rtcs_pkg::CTRL_SIGN_BIT];
    tone_d  = tone_q;
    pre_d   = pre_q;
    stage_d = stage_q;
    blank_d = blank_q;
    sec_d   = sec_q;
    min_d   = min_q;
    cal_d   = cal_q;
    tick_d  = 1'b0;
    if (cal_q == rtcs_pkg::CS_WAIT && adj_now) begin
      cal_d   = rtcs_pkg::CS_ADJ;
      blank_d = 8'h00;
    end
    if (ctrl_wr) begin
      tone_d  = '0;
      pre_d   = '0;
      stage_d = '0;
      cal_d   = rtcs_pkg::CS_WAIT;
    end else if (osc_edge) begin
      // Tone tapped before any blanking or insertion
      tone_d = tone_q + 1'b1;
      if (cal_q == rtcs_pkg::CS_ADJ && !pos) begin
        blank_d = blank_q + 8'h01;
        if (blank_q == rtcs_pkg::BLANK_CYCLES - 8'h01) begin
          cal_d = rtcs_pkg::CS_DONE;
        end
      end else begin
        pre_d = pre_q + 1'b1;
        if (&pre_q) begin
          // A double step into the next stage inserts 256 cycles
          if (cal_q == rtcs_pkg::CS_ADJ && pos) begin
            sum   = {1'b0, stage_q} + (rtcs_pkg::STAGE_W+1)'(2);
            cal_d = rtcs_pkg::CS_DONE;
          end else begin
            sum = {1'b0, stage_q} + (rtcs_pkg::STAGE_W+1)'(1);
          end
          stage_d = sum[rtcs_pkg::STAGE_W-1:0];
          if (sum[rtcs_pkg::STAGE_W]) begin
            tick_d = 1'b1;
            cal_d  = rtcs_pkg::CS_WAIT;
            if (sec_q == rtcs_pkg::SEC_LAST) begin
              sec_d = 6'h00;
              min_d = min_q + 6'h01;
            end else begin
              sec_d = sec_q + 6'h01;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tone_q  <= '0;
      pre_q   <= '0;
      stage_q <= '0;
      blank_q <= 8'h00;
      sec_q   <= 6'h00;
      min_q   <= 6'h00;
      cal_q   <= rtcs_pkg::CS_WAIT;
      tick_q  <= 1'b0;
    end else begin
      tone_q  <= tone_d;
      pre_q   <= pre_d;
      stage_q <= stage_d;
      blank_q <= blank_d;
      sec_q   <= sec_d;
      min_q   <= min_d;
      cal_q   <= cal_d;
      tick_q  <= tick_d;
    end
  end

  // Pin and charger switches, all from flops to avoid glitches outside
  always_comb begin
    logic key_ok;
    logic dio_ok;
    logic res_ok;
    key_ok = (chg_q[7:4] == rtcs_pkg::CHG_KEY);
    dio_ok = (chg_q[3:2] == rtcs_pkg::DIODE_NONE)
             || (chg_q[3:2] == rtcs_pkg::DIODE_ONE);
    res_ok = (chg_q[1:0] != rtcs_pkg::RES_OFF);
    if (ctrl_q[rtcs_pkg::CTRL_TONE_BIT]) begin
      pin_d = tone_q[rtcs_pkg::TONE_W-1];
    end else begin
      pin_d = ctrl_q[rtcs_pkg::CTRL_LEVEL_BIT];
    end
    if (key_ok && dio_ok && res_ok) begin
      sw_d = {1'b1, chg_q[3:2] == rtcs_pkg::DIODE_ONE,
              chg_q[1:0] == rtcs_pkg::RES_250,
              chg_q[1:0] == rtcs_pkg::RES_2K,
              chg_q[1:0] == rtcs_pkg::RES_4K};
    end else begin
      sw_d = 5'h00;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 1'b1;
      sw_q  <= 5'h00;
    end else begin
      pin_q <= pin_d;
      sw_q  <= sw_d;
    end
  end

  assign test_level_pin = pin_q;
  assign {chg_enable, chg_diode, chg_res_250, chg_res_2k, chg_res_4k} = sw_q;
  assign sec_tick  = tick_q;
  assign halt_flag = flag_q;
  assign reg_ptr   = ptr_q;
  assign rd_data   = rdat_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_level_follow;
    !ctrl_q[rtcs_pkg::CTRL_TONE_BIT] |=>
      test_level_pin == $past(ctrl_q[rtcs_pkg::CTRL_LEVEL_BIT]);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level pin wrong");
  property p_tone_out;
    ctrl_q[rtcs_pkg::CTRL_TONE_BIT] |=> test_level_pin == $past(tone_q[5]);
  endproperty
  a_tone_out: assert property (p_tone_out) else $error("pin lacks the tone");
  property p_key_gate;
    (chg_q[7:4] != rtcs_pkg::CHG_KEY) |=> !chg_enable;
  endproperty
  a_key_gate: assert property (p_key_gate) else $error("charger on without key");
  property p_diode_gate;
    (chg_q[3:2] == 2'h0 || chg_q[3:2] == 2'h3) |=> !chg_enable && !chg_diode;
  endproperty
  a_diode_gate: assert property (p_diode_gate) else $error("bad diode field");
  property p_res_map;
    (chg_q == 8'hA9) |=> chg_enable && chg_diode && chg_res_250 && !chg_res_2k && !chg_res_4k;
  endproperty
  a_res_map: assert property (p_res_map) else $error("resistor decode wrong");
  property p_halt_set;
    halt_evt |=> halt_flag;
  endproperty
  a_halt_set: assert property (p_halt_set) else $error("stop edge missed");
  property p_halt_hold;
    halt_flag && !flag_clr |=> halt_flag;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("flag dropped");
  property p_flag_low;
    ptr_q == rtcs_pkg::PTR_FLAG |=> rd_data[6:0] == 7'h00;
  endproperty
  a_flag_low: assert property (p_flag_low) else $error("flag low bits set");
  property p_blank_hold;
    cal_q == rtcs_pkg::CS_ADJ && !ctrl_q[rtcs_pkg::CTRL_SIGN_BIT]
      && osc_edge && !ctrl_wr |=> $stable(pre_q);
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("prescaler moved");
  property p_div_reset;
    ctrl_wr |=> pre_q == '0 && tone_q == '0 && stage_q == '0;
  endproperty
  a_div_reset: assert property (p_div_reset) else $error("divider not reset");
  property p_ptr_wrap;
    wr_stb && !ptr_load && ptr_q == rtcs_pkg::PTR_CTRL |=> reg_ptr == 8'h00;
  endproperty
  a_ptr_wrap: assert property (p_ptr_wrap) else $error("pointer did not wrap");

endmodule // rtcs_special_regs

`default_nettype wire

// >>> core/rtcs_pkg.sv
/*
  Shared constants for the clock's special-purpose registers: register
  pointers, field positions, reset values, charger codes, divider sizes
  and the oscillator stop timeout.
  Assumes a 40 MHz system clock and a 32768 Hz oscillator input.
*/
package rtcs_pkg;

  // Register pointers
  localparam logic [7:0] PTR_ZERO = 8'h00;
  localparam logic [7:0] PTR_CTRL = 8'h07;
  localparam logic [7:0] PTR_CHG  = 8'h08;
  localparam logic [7:0] PTR_FLAG = 8'h09;

  // Control register fields
  localparam int         CTRL_LEVEL_BIT = 7;
  localparam int         CTRL_TONE_BIT  = 6;
  localparam int         CTRL_SIGN_BIT  = 5;
  localparam int         TRIM_W         = 5;
  localparam logic [7:0] CTRL_RESET     = 8'h80;

  // Charge-select register fields and codes
  localparam logic [7:0] CHG_RESET  = 8'h00;
  localparam logic [3:0] CHG_KEY    = 4'hA;
  localparam logic [1:0] DIODE_NONE = 2'h1;
  localparam logic [1:0] DIODE_ONE  = 2'h2;
  localparam logic [1:0] RES_OFF    = 2'h0;
  localparam logic [1:0] RES_250    = 2'h1;
  localparam logic [1:0] RES_2K     = 2'h2;
  localparam logic [1:0] RES_4K     = 2'h3;

  // Flag register
  localparam int         FLAG_BIT   = 7;
  localparam logic       FLAG_RESET = 1'b1;

  // Divider chain: tone /64, prescale /256, stage /128 gives one second
  localparam int         TONE_W       = 6;
  localparam int         PRE_W        = 8;
  localparam int         STAGE_W      = 7;
  localparam logic [7:0] BLANK_CYCLES = 8'h80;
  localparam logic [5:0] SEC_LAST     = 6'h3B;
  localparam logic [5:0] ADJ_SECOND   = 6'h00;
  localparam logic [5:0] CAL_MIN_LIM  = 6'h3E;

  // Oscillator stop detection
  localparam int MCLK_PERIOD_NS   = 25;
  localparam int OSC_STOP_TIME_NS = 100000;
  localparam int OSC_STOP_CYCLES  = OSC_STOP_TIME_NS / MCLK_PERIOD_NS;
  localparam int STOP_W           = 12;

  // Calibration sequencer; one bit changes per step except done back to wait
  typedef enum logic [1:0] {
    CS_WAIT = 2'h0,
    CS_ADJ  = 2'h1,
    CS_DONE = 2'h3
  } rtcs_cal_t;

endpackage

// >>> core/rtcs_edge_sync.sv
/*
  Two-flop synchroniser with a rising-edge detector behind it.
  Assumes the input is asynchronous to mclk and much slower than it.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcs_edge_sync (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Asynchronous level in
  input  wire logic async_in,
  // Synchronised level and its rising edge
  output logic      level,
  output logic      rise
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;
  logic prev_q;
  logic prev_d;

  // Only the second stage reads the first one
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // Edge taken between synchronised stage and its delayed copy
  assign level = sync_q;
  assign rise  = sync_q & ~prev_q;

endmodule // rtcs_edge_sync

`default_nettype wire

// >>> tb/rtcs_host_model.sv
/*
  Byte-level master for the register port, standing where the serial
  slave would be. Assumes strobes are sampled on rising mclk.
*/
`timescale 1ns/1ps
`default_nettype none

module rtcs_host_model (
  // Clock
  input  wire logic       mclk,
  // Byte access
  output logic            ptr_load,
  output logic      [7:0] ptr_value,
  output logic            wr_stb,
  output logic      [7:0] wr_data,
  output logic            rd_stb,
  input  wire logic [7:0] rd_data
);
  // Quiet bus from time zero
  initial begin
    ptr_load  = 1'b0;
    ptr_value = 8'h00;
    wr_stb    = 1'b0;
    wr_data   = 8'h00;
    rd_stb    = 1'b0;
  end

  // One request (0 pointer, 1 write, 2 read) after gap idle cycles; data is
  // inverted once released so a stale byte never passes for a fresh one
  task automatic xfer(input int kind, input logic [7:0] v, input int gap,
                      output logic [7:0] d);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    #2;
    d         = rd_data;
    ptr_value = v;
    wr_data   = v;
    ptr_load  = (kind == 0);
    wr_stb    = (kind == 1);
    rd_stb    = (kind == 2);
    @(posedge mclk);
    #2;
    ptr_load  = 1'b0;
    wr_stb    = 1'b0;
    rd_stb    = 1'b0;
    ptr_value = ~v;
    wr_data   = ~v;
  endtask
endmodule // rtcs_host_model

`default_nettype wire

// >>> tb/tb.sv
/*
  Self-checking bench for the special-purpose registers: a byte master
  drives the port, a behavioural model predicts every read and pin.
  Assumes a 40 MHz mclk and a 200 ns oscillator period.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic       mclk, rst_n, osc_clk, osc_disable_n, osc_run, osc_enable;
  logic       ptr_load, wr_stb, rd_stb, test_level_pin, sec_tick, halt_flag;
  logic       chg_enable, chg_diode, chg_res_250, chg_res_2k, chg_res_4k;
  logic [7:0] ptr_value, wr_data, reg_ptr, rd_data, d, v8;
  int         n_mismatch   = 0;
  int         total_checks = 0;
  int         cycles       = 0;
  int         n_tick       = 0;
  int         seed         = 32'hf0a5333b;
  int         m_ptr, m_ctrl, m_chg, m_flag;

  rtcs_special_regs dut (
    .mclk (mclk), .rst_n (rst_n), .osc_clk (osc_clk),
    .osc_disable_n (osc_disable_n), .osc_enable (osc_enable),
    .ptr_load (ptr_load), .ptr_value (ptr_value), .wr_stb (wr_stb),
    .wr_data (wr_data), .rd_stb (rd_stb), .reg_ptr (reg_ptr), .rd_data (rd_data),
    .test_level_pin (test_level_pin), .sec_tick (sec_tick),
    .chg_enable (chg_enable), .chg_diode (chg_diode), .chg_res_250 (chg_res_250),
    .chg_res_2k (chg_res_2k), .chg_res_4k (chg_res_4k), .halt_flag (halt_flag)
  );

  rtcs_host_model host (
    .mclk (mclk), .ptr_load (ptr_load), .ptr_value (ptr_value), .wr_stb (wr_stb),
    .wr_data (wr_data), .rd_stb (rd_stb), .rd_data (rd_data)
  );

  // Pointer model: the two block ends wrap to zero
  function automatic int nxt(input int p);
    return (p == 7 || p == 9) ? 0 : (p + 1) % 256;
  endfunction

  // Byte the model expects at a pointer; unowned places read zero
  function automatic logic [7:0] exp_rd(input int p);
    return (p == 7) ? m_ctrl[7:0] : (p == 8) ? m_chg[7:0] :
           (p == 9) ? {m_flag[0], 7'h00} : 8'h00;
  endfunction

  // Charger switches: key, a valid diode code and a nonzero resistor together
  function automatic logic [7:0] exp_chg(input int v);
    logic on;
    on = (v[7:4] == 4'hA) && (v[3:2] == 2'h1 || v[3:2] == 2'h2) && (v[1:0] != 2'h0);
    return {3'h0, on, on & v[3], on & (v[1:0] == 2'h1), on & (v[1:0] == 2'h2),
            on & (v[1:0] == 2'h3)};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // One bus request with a random gap; reads wait one extra cycle for rd_data
  task automatic op(input int kind, input logic [7:0] v);
    host.xfer(kind, v, ($random(seed) & 3) + (kind == 2), d);
    if (kind == 2) check(d, exp_rd(m_ptr));
    if (kind == 0) m_ptr = v;
    else begin
      if (kind == 1 && m_ptr == 7) m_ctrl = v;
      if (kind == 1 && m_ptr == 8) m_chg = v;
      if (kind == 1 && m_ptr == 9 && !v[7]) m_flag = 0;
      m_ptr = nxt(m_ptr);
    end
    check(reg_ptr, m_ptr[7:0]);
  endtask

  // Pins one cycle after the register settles; tone reads low just after a write
  task automatic pins();
    @(posedge mclk);
    #2;
    check({7'h00, test_level_pin}, m_ctrl[6] ? 8'h00 : {7'h00, m_ctrl[7]});
    check({3'h0, chg_enable, chg_diode, chg_res_250, chg_res_2k, chg_res_4k},
          exp_chg(m_chg));
    check({7'h00, halt_flag}, {7'h00, m_flag[0]});
  endtask

  task automatic summarize();
    $display("Checks %0d, mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Oscillator stands still while disabled or failed, as a crystal would
  initial begin
    osc_clk = 1'b0;
    #37;
    forever #100 osc_clk = (osc_run && osc_enable) ? ~osc_clk : 1'b0;
  end

  // Any tick, or an unknown on the pin, is counted
  always @(posedge mclk) begin
    if (sec_tick !== 1'b0) n_tick <= n_tick + 1;
  end

  // Hang guard well above the planned run of some 10000 cycles
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      n_mismatch++;
      summarize();
    end
  end

  initial begin
    rst_n         = 1'b0;
    osc_disable_n = 1'b0;
    osc_run       = 1'b1;
    m_ptr         = 0;
    m_ctrl        = 32'h80;
    m_chg         = 0;
    m_flag        = 1;
    repeat (10) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    pins();
    // Reset contents, walking across both wrap points
    op(0, 8'h07);
    op(2, 8'h00);
    op(0, 8'h08);
    op(2, 8'h00);
    op(2, 8'h00);
    op(2, 8'h00);
    $display("Test reset finished");
    // Every charge code; supply taken as under the 250 ohm limit
    for (int v = 0; v < 256; v++) begin
      op(0, 8'h08);
      op(1, v[7:0]);
      pins();
      op(0, 8'h08);
      op(2, 8'h00);
    end
    $display("Test charge finished");
    // Level bit both ways, then random control bytes
    for (int i = 0; i < 10; i++) begin
      v8 = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'($random(seed));
      op(0, 8'h07);
      op(1, v8);
      pins();
      op(0, 8'h07);
      op(2, 8'h00);
    end
    // Tone phase after a control write, full trim of either sign
    for (int s = 0; s < 2; s++) begin
      op(0, 8'h07);
      op(1, s ? 8'h7F : 8'h5F);
      #5800 check({7'h00, test_level_pin}, 8'h00);
      #1100 check({7'h00, test_level_pin}, 8'h01);
      #6400 check({7'h00, test_level_pin}, 8'h00);
    end
    op(0, 8'h07);
    op(1, 8'h80);
    $display("Test control finished");
    // Clear by writing zero; a written one and the low bits change nothing
    op(0, 8'h09);
    op(1, 8'h7F);
    op(0, 8'h09);
    op(1, 8'hFF);
    op(0, 8'h09);
    op(2, 8'h00);
    // Disable bit stops the oscillator; the flag is set on that edge only
    osc_disable_n = 1'b1;
    m_flag        = 1;
    repeat (8) @(posedge mclk);
    #2;
    check({7'h00, osc_enable}, 8'h00);
    pins();
    op(0, 8'h09);
    op(1, 8'h00);
    repeat (20) @(posedge mclk);
    pins();
    osc_disable_n = 1'b0;
    repeat (200) @(posedge mclk);
    // A crystal failing on its own is another stop cause
    osc_run = 1'b0;
    m_flag  = 1;
    repeat (4200) @(posedge mclk);
    pins();
    osc_run = 1'b1;
    op(0, 8'h09);
    op(2, 8'h00);
    $display("Test flag finished");
    // A second reset brings back the power-up values over written ones
    op(0, 8'h08);
    op(1, 8'hA5);
    op(0, 8'h09);
    op(1, 8'h00);
    rst_n  = 1'b0;
    m_ptr  = 0;
    m_ctrl = 32'h80;
    m_chg  = 0;
    m_flag = 1;
    repeat (10) @(posedge mclk);
    #2;
    rst_n = 1'b1;
    pins();
    op(0, 8'h08);
    op(2, 8'h00);
    // One second takes 32768 oscillator edges, far more than this run gives
    check((n_tick > 255) ? 8'hFF : 8'(n_tick), 8'h00);
    $display("Test second reset finished");
    summarize();
  end
endmodule // tb

`default_nettype wire
